// ===== rtl/sdm_bank.sv
// sdram bank decode, access qualification and software-driven init commands
// assumes a simple register port and a system bus giving one access per pulse
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "sdm_params.svh"

// Contract
// [RULE1] set mask bits 31..18 ignore that address bit in the hit compare
// [RULE2] write protect bit 8 set blocks writes; clear allows reads and writes
// [RULE3] bit 6 set keeps cpu-space and interrupt-acknowledge cycles from hitting
// [RULE4] bit 5 set rejects accesses from masters other than the core
// [RULE5] bits 4 and 2 set exclude supervisor and user code fetches
// [RULE6] bits 3 and 1 clear allow supervisor and user data accesses
// [RULE7] mode-load request turns the next bank access into a mode-register set
// [RULE8] mode value is driven from mapped address bits onto sdram A[10:0]
// [RULE9] software places example mode fields on processor pins A20..A17, A9..A15
// [RULE10] software sets mask bit 19 before requesting mode load
// [RULE11] precharge request plus any bank write issues precharge-all; with mode-load request also set, that write issues mode-register set instead
// [RULE12] refresh enable starts periodic auto-refresh of the bank
// [RULE13] software keeps refresh enabled and performs one access for mode load
// [RULE14] column latency 00 gives read data one cycle after column strobe
// [RULE15] software programs config, base/control, mask before init steps
// [RULE16] valid bit 0 clear stops every hit on the bank
module sdm_bank
  import sdm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // system bus access
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  input wire logic bus_write,
  input wire logic bus_cpu_space,
  input wire logic bus_alt_master,
  input wire logic bus_supervisor,
  input wire logic bus_code,
  output logic bus_hit,
  output logic bus_refused,
  output logic read_valid,
  // sdram command side
  output sdm_cmd_type sdram_cmd,
  output logic [10:0] sdram_addr
);

  logic [15:0] control_reg, control_next;
  logic [31:0] addr_ctl_reg, addr_ctl_next;
  logic [31:0] mask_reg, mask_next;
  logic [31:0] rdata_reg, rdata_next;
  sdm_state_type state_reg, state_next;
  sdm_cmd_type cmd_reg, cmd_next;
  logic [10:0] saddr_reg, saddr_next;
  logic [10:0] refresh_cnt_reg, refresh_cnt_next;
  logic refresh_due_reg, refresh_due_next;
  logic [1:0] lat_cnt_reg, lat_cnt_next;
  logic valid_reg, valid_next;
  logic [2:0] done_reg, done_next;
  logic match;
  logic qualified;
  logic hit;

  // masked base compare
  function automatic logic addr_match(input logic [31:0] a, input logic [31:0] base,
                                      input logic [31:0] msk);
    logic [13:0] care;
    care = ~msk[`SDM_MASK_HI:`SDM_MASK_LO];
    addr_match = ((a[`SDM_MASK_HI:`SDM_MASK_LO] ^ base[`SDM_MASK_HI:`SDM_MASK_LO]) & care)
                 == 14'h0000; // RULE1
  endfunction

  // decode and qualification
  always_comb begin
    match = addr_match(bus_addr, addr_ctl_reg, mask_reg);
    qualified = 1'b1;
    if (!mask_reg[`SDM_BIT_V]) begin
      qualified = 1'b0; // RULE16
    end
    if (bus_write && mask_reg[`SDM_BIT_WP]) begin
      qualified = 1'b0; // RULE2
    end
    if (bus_cpu_space && mask_reg[`SDM_BIT_CI]) begin
      qualified = 1'b0; // RULE3
    end
    if (bus_alt_master && mask_reg[`SDM_BIT_AM]) begin
      qualified = 1'b0; // RULE4
    end
    if (!bus_cpu_space && bus_code) begin
      if (bus_supervisor && mask_reg[`SDM_BIT_SC]) begin
        qualified = 1'b0; // RULE5
      end
      if (!bus_supervisor && mask_reg[`SDM_BIT_UC]) begin
        qualified = 1'b0; // RULE5
      end
    end
    if (!bus_cpu_space && !bus_code) begin
      if (bus_supervisor && mask_reg[`SDM_BIT_SD]) begin
        qualified = 1'b0; // RULE6
      end
      if (!bus_supervisor && mask_reg[`SDM_BIT_UD]) begin
        qualified = 1'b0; // RULE6
      end
    end
    hit = bus_req && match && qualified && (state_reg == SDM_IDLE);
  end

  assign bus_hit = hit;
  assign bus_refused = bus_req && match && !qualified;

  // register file
  always_comb begin
    control_next = control_reg;
    addr_ctl_next = addr_ctl_reg;
    mask_next = mask_reg;
    rdata_next = `SDM_RST_WORD;
    if (reg_wr) begin
      if (reg_addr == `SDM_OFF_CONTROL) begin
        control_next = reg_wdata[15:0];
      end else if (reg_addr == `SDM_OFF_ADDR_CTL) begin
        addr_ctl_next = reg_wdata;
      end else if (reg_addr == `SDM_OFF_MASK) begin
        mask_next = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == `SDM_OFF_CONTROL) begin
        rdata_next = {16'h0000, control_reg};
      end else if (reg_addr == `SDM_OFF_ADDR_CTL) begin
        rdata_next = addr_ctl_reg;
      end else if (reg_addr == `SDM_OFF_MASK) begin
        rdata_next = mask_reg;
      end else if (reg_addr == `SDM_OFF_STATUS) begin
        rdata_next = {26'h0000000, refresh_due_reg, done_reg, state_reg[1:0]};
      end
    end
    // request bits clear once their command issues, unless rewritten now
    if (!(reg_wr && reg_addr == `SDM_OFF_ADDR_CTL)) begin
      if (state_next == SDM_PRECHARGE && state_reg != SDM_PRECHARGE) begin
        addr_ctl_next[`SDM_BIT_IP] = 1'b0;
      end
      if (state_next == SDM_MODE_SET && state_reg != SDM_MODE_SET) begin
        addr_ctl_next[`SDM_BIT_MODE_LOAD_REQUEST] = 1'b0;
      end
    end
  end

  // refresh interval timer
  always_comb begin
    refresh_cnt_next = refresh_cnt_reg;
    refresh_due_next = refresh_due_reg;
    if (!addr_ctl_reg[`SDM_BIT_RE]) begin
      refresh_cnt_next = 11'h000;
      refresh_due_next = 1'b0;
    end else begin
      if (refresh_cnt_reg == 11'h000) begin
        refresh_cnt_next = ({2'b00, control_reg[`SDM_RC_HI:`SDM_RC_LO]} + 11'h001) * 4'h1
                           * `SDM_RC_STEP; // RULE12
        refresh_due_next = 1'b1;
      end else begin
        refresh_cnt_next = refresh_cnt_reg - 11'h001;
      end
      if (state_next == SDM_REFRESH) begin
        refresh_due_next = 1'b0;
      end
    end
  end

  // command sequencer
  always_comb begin
    state_next = state_reg;
    cmd_next = SDM_CMD_NOP;
    saddr_next = saddr_reg;
    lat_cnt_next = lat_cnt_reg;
    valid_next = 1'b0;
    done_next = done_reg;
    case (state_reg)
      SDM_IDLE: begin
        if (hit && addr_ctl_reg[`SDM_BIT_MODE_LOAD_REQUEST]) begin
          state_next = SDM_MODE_SET; // RULE7
          cmd_next = SDM_CMD_MRS;
          saddr_next = {bus_addr[`SDM_ADDR_MODE_HI:`SDM_ADDR_MODE_HI - 3],
                        bus_addr[`SDM_ADDR_MODE_LO], bus_addr[10], bus_addr[11],
                        bus_addr[12], bus_addr[13], bus_addr[14], bus_addr[15]}; // RULE8
          done_next[2] = 1'b1;
        end else if (hit && bus_write && addr_ctl_reg[`SDM_BIT_IP]) begin
          state_next = SDM_PRECHARGE; // RULE11
          cmd_next = SDM_CMD_PALL;
          saddr_next = 11'h400;
          done_next[0] = 1'b1;
        end else if (refresh_due_reg && !bus_req) begin
          state_next = SDM_REFRESH; // RULE12
          cmd_next = SDM_CMD_REF;
          done_next[1] = 1'b1;
        end else if (hit) begin
          cmd_next = SDM_CMD_ACCESS;
          saddr_next = bus_addr[12:2];
          if (bus_write) begin
            state_next = SDM_ACCESS;
          end else begin
            state_next = SDM_DATA_WAIT;
            lat_cnt_next = control_reg[`SDM_COLUMN_LATENCY_HI:`SDM_COLUMN_LATENCY_LO]; // RULE14
          end
        end
      end
      SDM_DATA_WAIT: begin
        if (lat_cnt_reg == 2'b00) begin
          valid_next = 1'b1; // RULE14
          state_next = SDM_IDLE;
        end else begin
          lat_cnt_next = lat_cnt_reg - 2'b01;
        end
      end
      SDM_ACCESS, SDM_PRECHARGE, SDM_MODE_SET, SDM_REFRESH: begin
        state_next = SDM_IDLE;
      end
      default: begin
        state_next = SDM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control_reg <= `SDM_RST_CTL;
      addr_ctl_reg <= `SDM_RST_WORD;
      mask_reg <= `SDM_RST_WORD;
      rdata_reg <= `SDM_RST_WORD;
      state_reg <= SDM_IDLE;
      cmd_reg <= SDM_CMD_NOP;
      saddr_reg <= 11'h000;
      refresh_cnt_reg <= 11'h000;
      refresh_due_reg <= 1'b0;
      lat_cnt_reg <= 2'b00;
      valid_reg <= 1'b0;
      done_reg <= 3'b000;
    end else begin
      control_reg <= control_next;
      addr_ctl_reg <= addr_ctl_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      saddr_reg <= saddr_next;
      refresh_cnt_reg <= refresh_cnt_next;
      refresh_due_reg <= refresh_due_next;
      lat_cnt_reg <= lat_cnt_next;
      valid_reg <= valid_next;
      done_reg <= done_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign sdram_cmd = cmd_reg;
  assign sdram_addr = saddr_reg;
  assign read_valid = valid_reg;

endmodule // sdm_bank

// ===== include/sdm_params.svh
// constants for the sdram bank mask and init sequencer
// assumes one 10 MHz clock and a synchronous active-high reset
`ifndef SDM_PARAMS_SVH
`define SDM_PARAMS_SVH
`define SDM_OFF_CONTROL 4'h0
`define SDM_OFF_ADDR_CTL 4'h4
`define SDM_OFF_MASK 4'h8
`define SDM_OFF_STATUS 4'hC
`define SDM_MASK_HI 31
`define SDM_MASK_LO 18
`define SDM_BIT_WP 8
`define SDM_BIT_CI 6
`define SDM_BIT_AM 5
`define SDM_BIT_SC 4
`define SDM_BIT_SD 3
`define SDM_BIT_UC 2
`define SDM_BIT_UD 1
`define SDM_BIT_V 0
`define SDM_BIT_RE 15
`define SDM_COLUMN_LATENCY_HI 13
`define SDM_COLUMN_LATENCY_LO 12
`define SDM_BIT_MODE_LOAD_REQUEST 6
`define SDM_BIT_IP 3
`define SDM_RC_HI 8
`define SDM_RC_LO 0
`define SDM_RST_CTL 16'h0000
`define SDM_RST_WORD 32'h00000000
`define SDM_RC_STEP 11'h010
`define SDM_MODE_HI 10
`define SDM_MODE_LO 0
`define SDM_ADDR_MODE_HI 20
`define SDM_ADDR_MODE_LO 9
`define SDM_SIG_LEN 2'h2
`endif

// ===== include/sdm_pkg.sv
// types for the sdram bank mask and init sequencer
// assumes nothing beyond the params header
package sdm_pkg;
  typedef enum logic [2:0] {
    SDM_IDLE = 3'b000,
    SDM_ACCESS = 3'b001,
    SDM_PRECHARGE = 3'b010,
    SDM_MODE_SET = 3'b011,
    SDM_REFRESH = 3'b100,
    SDM_DATA_WAIT = 3'b101
  } sdm_state_type;
  typedef enum logic [2:0] {
    SDM_CMD_NOP = 3'b000,
    SDM_CMD_ACCESS = 3'b001,
    SDM_CMD_PALL = 3'b010,
    SDM_CMD_MRS = 3'b011,
    SDM_CMD_REF = 3'b100
  } sdm_cmd_type;
endpackage

// ===== dv/sdm_sdram_model.sv
// behavioural sdram component on the command pins
// assumes commands stand one clock with their address beside them
`timescale 1ns/100ps
module sdm_sdram_model
  import sdm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // command pins
  input wire sdm_cmd_type sdram_cmd,
  input wire logic [10:0] sdram_addr,
  // observed state
  output logic [10:0] mode_reg,
  output logic [7:0] ref_cnt
);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_reg <= 11'h000;
      ref_cnt <= 8'h00;
    end else begin
      if (sdram_cmd == SDM_CMD_MRS) begin
        mode_reg <= sdram_addr;
      end
      if (sdram_cmd == SDM_CMD_REF) begin
        ref_cnt <= ref_cnt + 8'h01;
      end
    end
  end
endmodule // sdm_sdram_model

// ===== dv/sdm_bank_asserts.sv
// checker for the sdram bank: hit qualification and command relations
// assumes only the top-level ports of the bank are visible
`timescale 1ns/100ps
module sdm_bank_asserts
  import sdm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // bus and sdram side
  input wire logic [31:0] bus_addr,
  input wire logic bus_write,
  input wire logic bus_cpu_space,
  input wire logic bus_alt_master,
  input wire logic bus_supervisor,
  input wire logic bus_code,
  input wire logic bus_hit,
  input wire logic read_valid,
  input wire sdm_cmd_type sdram_cmd,
  input wire logic [10:0] sdram_addr
);
  logic [31:0] ctl_reg, ctl_next, msk_reg, msk_next;
  wire [10:0] mode_w = {bus_addr[20:17], bus_addr[9], bus_addr[10], bus_addr[11],
    bus_addr[12], bus_addr[13], bus_addr[14], bus_addr[15]};
  // mirror of control and mask, with the one-shot bits self-clearing
  always_comb begin
    ctl_next = ctl_reg;
    msk_next = msk_reg;
    if (bus_hit) ctl_next[6] = 1'b0;
    if (bus_hit && bus_write && !ctl_reg[6]) ctl_next[3] = 1'b0;
    if (reg_wr && reg_addr == 4'h4) ctl_next = reg_wdata;
    if (reg_wr && reg_addr == 4'h8) msk_next = reg_wdata;
  end
  always_ff @(posedge clk) begin
    ctl_reg <= sys_rst ? 32'h00000000 : ctl_next;
    msk_reg <= sys_rst ? 32'h00000000 : msk_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd; bus_hit && !bus_write && !ctl_reg[6] && ctl_reg[13:12] == 2'h0; endsequence
  sequence s_rd_done; sdram_cmd == SDM_CMD_ACCESS ##1 read_valid; endsequence
  property p_base; bus_hit |-> ((bus_addr ^ ctl_reg) & ~msk_reg & 32'hFFFC0000) == 0; endproperty
  property p_wp; bus_hit && bus_write |-> !msk_reg[8]; endproperty
  property p_cpu; bus_hit |-> !(bus_cpu_space && msk_reg[6]); endproperty
  property p_am; bus_hit |-> !(bus_alt_master && msk_reg[5]); endproperty
  property p_code; bus_hit && bus_code && !bus_cpu_space |->
    !msk_reg[bus_supervisor ? 4 : 2]; endproperty
  property p_valid; !msk_reg[0] |-> !bus_hit; endproperty
  property p_read; s_rd |=> s_rd_done; endproperty
  property p_mrs; bus_hit && ctl_reg[6] |=> sdram_cmd == SDM_CMD_MRS
    && sdram_addr == $past(mode_w); endproperty
  property p_pall; bus_hit && bus_write && ctl_reg[3] && !ctl_reg[6] |=>
    sdram_cmd == SDM_CMD_PALL && sdram_addr == 11'h400; endproperty
  property p_ref; sdram_cmd == SDM_CMD_REF |-> $past(ctl_reg[15]); endproperty
  a_base: assert property (p_base) else $error("hit off masked base");
  a_wp: assert property (p_wp) else $error("write hit while protected");
  a_cpu: assert property (p_cpu) else $error("cpu space hit");
  a_am: assert property (p_am) else $error("alternate master hit");
  a_code: assert property (p_code) else $error("code fetch hit");
  a_valid: assert property (p_valid) else $error("hit with valid clear");
  a_read: assert property (p_read) else $error("read latency wrong");
  a_mrs: assert property (p_mrs) else $error("mode load wrong");
  a_pall: assert property (p_pall) else $error("precharge wrong");
  a_ref: assert property (p_ref) else $error("refresh while off");
endmodule // sdm_bank_asserts
bind sdm_bank sdm_bank_asserts i_sdm_bank_asserts (.clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .bus_addr, .bus_write, .bus_cpu_space, .bus_alt_master, .bus_supervisor,
  .bus_code, .bus_hit, .read_valid, .sdram_cmd, .sdram_addr);

// ===== dv/sdm_bank_tb.sv
// self-checking bench for the sdram bank mask and init sequencer
// assumes the package, bank, sdram model and checker are compiled first
`timescale 1ns/100ps
module sdm_bank_tb;
  import sdm_pkg::*;
  logic clk, sys_rst, reg_wr, reg_rd, bus_req, bus_write, bus_cpu_space, bus_alt_master;
  logic bus_supervisor, bus_code, bus_hit, bus_refused, read_valid, rv_seen, rf_seen;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, bus_addr;
  logic [10:0] sdram_addr, mode_reg;
  logic [7:0] ref_cnt;
  sdm_cmd_type sdram_cmd, cmd_seen;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  localparam logic [31:0] A = 32'hFF880020;
  sdm_bank i_sdm_bank (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bus_req, .bus_addr, .bus_write, .bus_cpu_space, .bus_alt_master, .bus_supervisor,
    .bus_code, .bus_hit, .bus_refused, .read_valid, .sdram_cmd, .sdram_addr);
  sdm_sdram_model i_sdm_sdram_model (.clk, .sys_rst, .sdram_cmd, .sdram_addr, .mode_reg,
    .ref_cnt);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", exp, reg_rdata);
  endtask
  // q holds cpu space, alternate master, supervisor, code
  task automatic acc(input logic [31:0] a, input logic w, input logic [3:0] q, input logic eh);
    int n;
    @(posedge clk);
    bus_addr <= a;
    bus_write <= w;
    {bus_cpu_space, bus_alt_master, bus_supervisor, bus_code} <= q;
    bus_req <= 1'b1;
    n = 0;
    @(negedge clk);
    while (eh && bus_hit !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    rf_seen = bus_refused;
    chk("bus_hit", {31'h0, eh}, {31'h0, bus_hit});
    @(posedge clk);
    bus_req <= 1'b0;
    @(negedge clk);
    cmd_seen = sdram_cmd;
    @(negedge clk);
    rv_seen = read_valid;
  endtask
  task automatic t_reset;
    rd(4'h8, 32'h0);
    wr(4'h2, 32'hFFFFFFFF);
    rd(4'h2, 32'h0);
    acc(32'h0, 1'b0, 4'h2, 1'b0);
  endtask
  task automatic t_qualify;
    wr(4'h0, 32'h2);
    wr(4'h4, 32'hFF880300);
    wr(4'h8, 32'h00740075);
    rd(4'h8, 32'h00740075);
    acc(A, 1'b0, 4'h2, 1'b1);
    chk("read cmd", {29'h0, SDM_CMD_ACCESS}, {29'h0, cmd_seen});
    chk("read_valid", 32'h1, {31'h0, rv_seen});
    acc(A, 1'b1, 4'h0, 1'b1);
    acc(A, 1'b0, 4'hA, 1'b0);
    chk("bus_refused", 32'h1, {31'h0, rf_seen});
    acc(A, 1'b0, 4'h6, 1'b0);
    acc(A, 1'b0, 4'h3, 1'b0);
    acc(A, 1'b0, 4'h1, 1'b0);
    acc(32'hFF980020, 1'b0, 4'h2, 1'b1);
    acc(32'hFF080020, 1'b0, 4'h2, 1'b0);
    chk("bus_refused", 32'h0, {31'h0, rf_seen});
    wr(4'h8, 32'h00740175);
    acc(A, 1'b1, 4'h2, 1'b0);
    acc(A, 1'b0, 4'h2, 1'b1);
    wr(4'h8, 32'h00740074);
    acc(A, 1'b0, 4'h2, 1'b0);
    wr(4'h8, 32'h00740075);
  endtask
  task automatic t_precharge_refresh;
    int n;
    wr(4'h4, 32'hFF880308);
    acc(32'hFF880000, 1'b1, 4'h2, 1'b1);
    chk("precharge cmd", {29'h0, SDM_CMD_PALL}, {29'h0, cmd_seen});
    wr(4'h4, 32'hFF888300);
    for (n = 0; n < 200 && ref_cnt == 8'h00; n++) @(posedge clk);
    chk("refresh seen", 32'h1, {31'h0, ref_cnt != 8'h00});
  endtask
  task automatic t_mode_load;
    wr(4'h8, 32'h00680075);
    wr(4'h4, 32'hFF888340);
    acc(32'hFF800800, 1'b1, 4'h2, 1'b1);
    chk("mode cmd", {29'h0, SDM_CMD_MRS}, {29'h0, cmd_seen});
    chk("mode value", 32'h010, {21'h0, mode_reg});
    acc(32'hFF880040, 1'b0, 4'h2, 1'b1);
    chk("next cmd", {29'h0, SDM_CMD_ACCESS}, {29'h0, cmd_seen});
  endtask
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, bus_req, bus_write, bus_cpu_space} = 5'h0;
    {bus_alt_master, bus_supervisor, bus_code} = 3'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    bus_addr = 32'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_qualify;
    t_precharge_refresh;
    t_mode_load;
    wrap_up;
  end
endmodule // sdm_bank_tb
